// ---- logic/sed_pkg.sv ----
// Constants shared by both ends of the two-wire EEPROM read link.
// Assumes a single 100 MHz clock domain on each end; the link clock is sampled.
// What this block does
// - Read begins with address byte, direction bit high
// - Counter holds last accessed address plus one
// - Counter kept between transactions without reload
// - Read address wraps last page to first
// - Acked read address shifts byte out MSB first
// - Master ends single read with nack, stop
// - Random read: dummy write, repeated start, read
// - Device acks dummy write, outputs loaded byte
// - Device increments after each byte; master ack makes it continue
// - Sequential read rolls over at top, continues
// - Master ends sequential read with nack, stop
// - Alternate type reads ID page, low five bits
// - Master keeps ID page reads within page
// - Lock probe data byte acked only if unlocked
// - One pointer shared by array and serial block
// - Serial access needs address bits eleven, ten one-zero
// - Master reads whole serial from pointer zero; the bench also reads serial byte three alone
// - Sixteen zero bytes follow serial, then wrap
// - Master ends serial read with nack, stop
// - Accept address only with one-zero-one-zero or one-zero-one-one preamble
// - Chip select bits must match select pins
package sed_pkg;
    localparam logic [3:0]  SED_TYPE_MAIN   = 4'ha;
    localparam logic [3:0]  SED_TYPE_ALT    = 4'hb;
    localparam int          SED_ADDR_W      = 13;
    localparam int          SED_MEM_BYTES   = 8192;
    localparam int          SED_PAGE_BYTES  = 32;
    localparam int          SED_SN_BYTES    = 16;
    localparam logic [1:0]  SED_SN_SEL      = 2'h2;
    localparam int          SED_SN_BIT_HI   = 11;
    localparam int          SED_LOCK_BIT    = 10;
    localparam int          SED_LINK_DIV    = 4;
    localparam int          SED_FIFO_DEPTH  = 8;
    localparam logic [7:0]  SED_CMD_WRITE   = 8'h00;
    localparam logic [7:0]  SED_CMD_READ    = 8'h01;
    typedef enum logic [1:0] {
        SED_OP_CUR,
        SED_OP_RAND,
        SED_OP_PROBE
    } sed_op_e;
endpackage

// ---- logic/sed_link_if.sv ----
// Two-wire link joining the master end and the memory end.
// Open-drain levels are resolved here from the output enables (low = drive low).
`timescale 1ns/1ps
`default_nettype none
interface sed_link_if;
    logic scl_oe_n;
    logic sda_m_oe_n;
    logic sda_s_oe_n;
    wire  scl = scl_oe_n;
    wire  sda = sda_m_oe_n & sda_s_oe_n;
    modport master (output scl_oe_n, output sda_m_oe_n, input scl, input sda);
    modport device (output sda_s_oe_n, input scl, input sda);
endinterface
`default_nettype wire

// ---- logic/sed_fifo.sv ----
// Parameterised FIFO with valid/ready on both sides.
// Assumes one clock; the drain side may stall freely.
`timescale 1ns/1ps
`default_nettype none
module sed_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0]   cnt_q;
    wire push = in_valid & in_ready;
    wire pop  = out_valid & out_ready;
    assign in_ready  = (cnt_q != (AW+1)'(D));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem[rp_q];
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_q] <= in_data;
        end
        if (srst) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) wp_q <= (wp_q == AW'(D-1)) ? '0 : wp_q + 1'b1;
            if (pop)  rp_q <= (rp_q == AW'(D-1)) ? '0 : rp_q + 1'b1;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// ---- logic/sed_device.sv ----
// Memory end: two-wire slave serving reads, address pointer, ID page and serial.
// Assumes scl/sda come from the link asynchronously; sampled with three flops.
`timescale 1ns/1ps
`default_nettype none
module sed_device
    import sed_pkg::*;
#(
    parameter int AW = sed_pkg::SED_ADDR_W
) (
    input  wire logic       clk,
    input  wire logic       srst,
    sed_link_if.device      link,
    input  wire logic [2:0] chip_sel,
    input  wire logic       id_locked,
    output logic            busy,
    output logic [7:0]      last_byte
);
    import sed_pkg::*;
    typedef enum logic [2:0] {
        SD_IDLE, SD_DEVADR, SD_WA_HI, SD_WA_LO, SD_WDATA, SD_READ, SD_DONE
    } sed_dev_e;

    logic [7:0] mem    [SED_MEM_BYTES];
    logic [7:0] idpage [SED_PAGE_BYTES];
    logic [7:0] serial [SED_SN_BYTES];
    initial begin
        for (int i = 0; i < SED_MEM_BYTES; i++) mem[i] = 8'(i);
        for (int i = 0; i < SED_PAGE_BYTES; i++) idpage[i] = 8'(8'h80 + i);
        for (int i = 0; i < SED_SN_BYTES; i++) serial[i] = 8'(8'hc0 + i);
    end

    logic [2:0] scl_s_q, sda_s_q;
    always_ff @(posedge clk) begin
        scl_s_q <= {scl_s_q[1:0], link.scl};
        sda_s_q <= {sda_s_q[1:0], link.sda};
    end
    wire scl_rise = scl_s_q[1] & ~scl_s_q[2];
    wire scl_fall = ~scl_s_q[1] & scl_s_q[2];
    // Clock must be high on both samples: data moving with a clock rise is no start or stop
    wire start_c  = scl_s_q[1] & scl_s_q[2] & ~sda_s_q[1] & sda_s_q[2];
    wire stop_c   = scl_s_q[1] & scl_s_q[2] & sda_s_q[1] & ~sda_s_q[2];

    sed_dev_e    st_q;
    logic [3:0]  bit_q;
    logic [7:0]  sh_q;
    logic        ackph_q;
    logic        alt_q;
    logic        serial_q;
    logic        lock_q;
    logic [AW-1:0] ptr_q;
    logic        oe_n_q;
    logic [7:0]  last_q;

    wire [7:0] sn_byte  = ptr_q[4] ? 8'h00 : serial[ptr_q[3:0]];
    wire [7:0] rd_byte  = !alt_q ? mem[ptr_q] :
                          serial_q ? sn_byte : idpage[ptr_q[4:0]];
    wire       adr_ok   = (sh_q[7:4] == SED_TYPE_MAIN || sh_q[7:4] == SED_TYPE_ALT)
                          && sh_q[3:1] == chip_sel;
    wire [AW-1:0] ptr_inc =
        !alt_q ? ptr_q + 1'b1 :
        serial_q ? {ptr_q[AW-1:5], ptr_q[4:0] + 5'h1} :
        {ptr_q[AW-1:5], ptr_q[4:0] + 5'h1};

    always_ff @(posedge clk) begin
        if (srst) begin
            st_q <= SD_IDLE; bit_q <= '0; sh_q <= '0; ackph_q <= 1'b0;
            alt_q <= 1'b0; serial_q <= 1'b0; lock_q <= 1'b0;
            ptr_q <= '0; oe_n_q <= 1'b1; last_q <= '0;
        end else if (start_c) begin
            st_q <= SD_DEVADR; bit_q <= '0; ackph_q <= 1'b0; oe_n_q <= 1'b1;
        end else if (stop_c) begin
            st_q <= SD_IDLE; oe_n_q <= 1'b1;
        end else if (scl_rise && !ackph_q && st_q != SD_IDLE && st_q != SD_DONE) begin
            if (st_q != SD_READ) sh_q <= {sh_q[6:0], sda_s_q[1]};
            bit_q <= bit_q + 4'h1;
        end else if (scl_rise && ackph_q && st_q == SD_READ && sda_s_q[1]) begin
            st_q <= SD_DONE;
        end else if (scl_fall) begin
            if (ackph_q) begin
                ackph_q <= 1'b0; bit_q <= '0; oe_n_q <= 1'b1;
                if (st_q == SD_READ) begin
                    oe_n_q <= rd_byte[7]; sh_q <= rd_byte; last_q <= rd_byte;
                end
                if (st_q == SD_DONE) oe_n_q <= 1'b1;
            end else if (st_q == SD_READ && bit_q != 4'h8) begin
                oe_n_q <= sh_q[6]; sh_q <= {sh_q[6:0], 1'b0};
            end else if (bit_q == 4'h8) begin
                ackph_q <= 1'b1;
                case (st_q)
                    SD_DEVADR: begin
                        if (adr_ok) begin
                            oe_n_q <= 1'b0;
                            alt_q  <= (sh_q[7:4] == SED_TYPE_ALT);
                            st_q   <= sh_q[0] ? SD_READ : SD_WA_HI;
                        end else begin
                            st_q <= SD_IDLE;
                        end
                    end
                    SD_WA_HI: begin
                        oe_n_q <= 1'b0;
                        serial_q <= (sh_q[SED_SN_BIT_HI-8 -: 2] == SED_SN_SEL);
                        lock_q   <= sh_q[SED_LOCK_BIT-8];
                        ptr_q[AW-1:8] <= sh_q[AW-9:0];
                        st_q <= SD_WA_LO;
                    end
                    SD_WA_LO: begin
                        oe_n_q <= 1'b0;
                        ptr_q[7:0] <= sh_q;
                        st_q <= SD_WDATA;
                    end
                    SD_WDATA: begin
                        oe_n_q <= !(alt_q && !id_locked);
                        st_q <= SD_DONE;
                    end
                    SD_READ: begin
                        oe_n_q <= 1'b1;
                        ptr_q <= ptr_inc;
                    end
                    default: st_q <= SD_IDLE;
                endcase
            end
        end
    end

    // Read data loaded at the fall that ends the address ack
    always_ff @(posedge clk) begin
        if (srst) busy <= 1'b0;
        else busy <= (st_q != SD_IDLE);
    end
    assign last_byte = last_q;
    assign link.sda_s_oe_n = oe_n_q;
endmodule
`default_nettype wire

// ---- logic/sed_master.sv ----
// Master end: drives the link clock by a divider and runs read commands.
// Received bytes pass through a FIFO; a full FIFO stalls the clock.
`timescale 1ns/1ps
`default_nettype none
module sed_master
    import sed_pkg::*;
(
    input  wire logic           clk,
    input  wire logic           srst,
    sed_link_if.master          link,
    input  wire logic           cmd_valid,
    output logic                cmd_ready,
    input  wire sed_pkg::sed_op_e cmd_op,
    input  wire logic [2:0]     cmd_sel,
    input  wire logic           cmd_alt,
    input  wire logic [15:0]    cmd_addr,
    input  wire logic [7:0]     cmd_len,
    output logic [7:0]          rx_data,
    output logic                rx_valid,
    input  wire logic           rx_ready,
    output logic                probe_ack,
    output logic                probe_done
);
    import sed_pkg::*;
    typedef enum logic [2:0] {
        SM_IDLE, SM_START, SM_TX, SM_RX, SM_STOP
    } sed_mst_e;

    logic [7:0] fin_data;
    logic       fin_valid, fin_ready;
    sed_fifo #(.W(8), .D(SED_FIFO_DEPTH)) u_fifo (
        .clk(clk), .srst(srst),
        .in_data(fin_data), .in_valid(fin_valid), .in_ready(fin_ready),
        .out_data(rx_data), .out_valid(rx_valid), .out_ready(rx_ready)
    );

    logic sda_s1_q, sda_s2_q;
    always_ff @(posedge clk) begin
        sda_s1_q <= link.sda;
        sda_s2_q <= sda_s1_q;
    end

    sed_mst_e   st_q;
    logic [1:0] ph_q;
    logic [3:0] bit_q;
    logic [7:0] sh_q;
    logic [2:0] step_q;
    logic [7:0] left_q;
    logic       scl_q, sda_q, fv_q, pack_q, pdone_q, rdy_q;
    sed_op_e    op_q;
    logic [2:0] sel_q;
    logic       alt_q;
    logic [15:0] addr_q;

    wire [7:0] dev_byte = {alt_q ? SED_TYPE_ALT : SED_TYPE_MAIN, sel_q, 1'b0};
    wire       tick     = (ph_q == 2'(SED_LINK_DIV-1));
    wire       stall    = (st_q == SM_RX) && bit_q == 4'h0 && ph_q == 2'h0 && !fin_ready;
    wire [7:0] tx_next  = (step_q == 3'h0) ? (dev_byte | ((op_q == SED_OP_CUR) ? 8'h01 : 8'h00)) :
                          (step_q == 3'h1) ? addr_q[15:8] :
                          (step_q == 3'h2) ? addr_q[7:0] :
                          (step_q == 3'h3) ? (op_q == SED_OP_PROBE ? 8'h02 : dev_byte | 8'h01) :
                          8'h00;

    always_ff @(posedge clk) begin
        if (srst) begin
            st_q <= SM_IDLE; ph_q <= '0; bit_q <= '0; sh_q <= '0; step_q <= '0;
            left_q <= '0; scl_q <= 1'b1; sda_q <= 1'b1; fv_q <= 1'b0;
            pack_q <= 1'b0; pdone_q <= 1'b0; rdy_q <= 1'b1;
            op_q <= SED_OP_CUR; sel_q <= '0; alt_q <= 1'b0; addr_q <= '0;
        end else begin
            fv_q <= 1'b0;
            pdone_q <= 1'b0;
            if (!stall) ph_q <= tick ? 2'h0 : ph_q + 2'h1;
            case (st_q)
                SM_IDLE: if (cmd_valid) begin
                    op_q <= cmd_op; sel_q <= cmd_sel; alt_q <= cmd_alt;
                    addr_q <= cmd_addr; left_q <= cmd_len; step_q <= 3'h0;
                    rdy_q <= 1'b0; st_q <= SM_START;
                end
                SM_START: if (tick) begin
                    // Start or repeated start: release and raise clock together, pull data, drop clock
                    if (!scl_q) begin sda_q <= 1'b1; scl_q <= 1'b1; end
                    else if (sda_q) sda_q <= 1'b0;
                    else begin
                        scl_q <= 1'b0; sh_q <= tx_next; bit_q <= '0; st_q <= SM_TX;
                    end
                end
                SM_TX: if (tick) begin
                    if (!scl_q) begin
                        sda_q <= (bit_q == 4'h8) ? 1'b1 : sh_q[7];
                        scl_q <= 1'b1;
                    end else begin
                        scl_q <= 1'b0;
                        if (bit_q == 4'h8) begin
                            step_q <= step_q + 3'h1;
                            if (step_q == 3'h4) begin
                                pack_q <= !sda_s2_q; pdone_q <= 1'b1; st_q <= SM_STOP;
                            end else if (sda_s2_q) st_q <= SM_STOP;
                            else if (step_q == 3'h0 && op_q == SED_OP_CUR) begin
                                bit_q <= '0; st_q <= SM_RX;
                            end else if (step_q == 3'h2 && op_q == SED_OP_RAND) begin
                                step_q <= 3'h3; st_q <= SM_START;
                            end else if (step_q == 3'h3 && op_q == SED_OP_RAND) begin
                                bit_q <= '0; st_q <= SM_RX;
                            end else begin
                                // Next byte follows the step just acknowledged
                                sh_q <= (step_q == 3'h0) ? addr_q[15:8] : addr_q[7:0];
                                bit_q <= '0;
                                if (step_q == 3'h2) begin sh_q <= 8'h02; step_q <= 3'h4; end
                            end
                        end else begin
                            sh_q <= {sh_q[6:0], 1'b0}; bit_q <= bit_q + 4'h1;
                        end
                    end
                end
                SM_RX: if (tick && !stall) begin
                    if (!scl_q) begin
                        sda_q <= (bit_q == 4'h8) ? (left_q == 8'h1) : 1'b1;
                        scl_q <= 1'b1;
                    end else begin
                        scl_q <= 1'b0;
                        if (bit_q == 4'h8) begin
                            left_q <= left_q - 8'h1; bit_q <= '0;
                            if (left_q == 8'h1) st_q <= SM_STOP;
                        end else begin
                            sh_q <= {sh_q[6:0], sda_s2_q}; bit_q <= bit_q + 4'h1;
                            if (bit_q == 4'h7) begin
                                fin_data <= {sh_q[6:0], sda_s2_q}; fv_q <= 1'b1;
                            end
                        end
                    end
                end
                SM_STOP: if (tick) begin
                    if (!scl_q && sda_q) sda_q <= 1'b0;
                    else if (!scl_q) scl_q <= 1'b1;
                    else if (!sda_q) sda_q <= 1'b1;
                    else begin st_q <= SM_IDLE; rdy_q <= 1'b1; end
                end
                default: st_q <= SM_IDLE;
            endcase
        end
    end
    assign fin_valid  = fv_q;
    assign cmd_ready  = rdy_q;
    assign probe_ack  = pack_q;
    assign probe_done = pdone_q;
    assign link.scl_oe_n   = scl_q;
    assign link.sda_m_oe_n = sda_q;
endmodule
`default_nettype wire

// ---- testbench/sed_link_assertions.sv ----
// Checker on the two-wire link between the master end and the memory end.
// Assumes one clk domain, srst synchronous high, link signals as plain inputs.
`timescale 1ns/1ps
`default_nettype none
module sed_link_assertions (
    input wire logic clk,
    input wire logic srst,
    input wire logic scl_oe_n,
    input wire logic sda_m_oe_n,
    input wire logic sda_s_oe_n,
    input wire logic scl,
    input wire logic sda
);
    logic       sda_q;
    logic       scl_q;
    logic       in_frame_q;
    logic       in_frame_d;
    logic [3:0] bit_cnt_q;
    logic [3:0] bit_cnt_d;
    wire        start_w = scl && scl_q && sda_q && !sda;
    wire        stop_w  = scl && scl_q && !sda_q && sda;
    wire        rise_w  = scl && !scl_q;
    // Saturating count of clock pulses since the last start
    assign bit_cnt_d  = start_w ? 4'h0 : ((rise_w && bit_cnt_q != 4'hf) ? bit_cnt_q + 4'h1 : bit_cnt_q);
    assign in_frame_d = start_w ? 1'b1 : (stop_w ? 1'b0 : in_frame_q);
    always_ff @(posedge clk) begin
        sda_q      <= sda;
        scl_q      <= scl;
        in_frame_q <= srst ? 1'b0 : in_frame_d;
        bit_cnt_q  <= srst ? 4'h0 : bit_cnt_d;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    reset_release_a: assert property ($fell(srst) |-> scl && sda_m_oe_n && sda_s_oe_n)
        else $error("link not released after reset");
    start_master_a: assert property (start_w |-> !sda_m_oe_n)
        else $error("start not made by master");
    start_clock_a: assert property (start_w |-> ##[1:40] !scl)
        else $error("no clock after start");
    drive_frame_a: assert property (!sda_s_oe_n |-> in_frame_q)
        else $error("memory end drives outside a frame");
    stop_release_a: assert property (stop_w |-> sda_s_oe_n ##1 sda_s_oe_n)
        else $error("memory end drives at stop");
    no_clash_a: assert property ((scl && !sda_s_oe_n) |-> sda_m_oe_n)
        else $error("both ends drive data while clock high");
    scl_high_len_a: assert property ($rose(scl) |-> scl[*2])
        else $error("link clock high too short");
    addr_quiet_a: assert property ((scl && scl_q && !sda_s_oe_n) |-> bit_cnt_q >= 4'h9)
        else $error("memory end drives during address bits");
    start_c: cover property (start_w);
    dev_ack_c: cover property (scl && !sda_s_oe_n && bit_cnt_q == 4'h9);
    stop_c: cover property (stop_w);
endmodule
`default_nettype wire

// ---- testbench/serial_eeprom_read_ops_bench.sv ----
// Bench joining master end and memory end over the two-wire link.
// Assumes preload: byte = address low byte, ID page 80+i, serial c0+i.
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_read_ops_bench;
    import sed_pkg::*;
    logic        clk;
    logic        srst;
    logic [2:0]  chip_sel;
    logic        id_locked;
    logic        cmd_valid;
    sed_op_e     cmd_op;
    logic [2:0]  cmd_sel;
    logic        cmd_alt;
    logic [15:0] cmd_addr;
    logic [7:0]  cmd_len;
    logic        rx_ready;
    logic        stall;
    logic [31:0] rdy_pat;
    logic [31:0] r;
    logic        cmd_ready;
    logic [7:0]  rx_data;
    logic        rx_valid;
    logic        probe_ack;
    logic        probe_done;
    logic [7:0]  last_byte;
    logic        dev_busy;
    logic [7:0]  exp_q[$];
    int          num_errors;
    int          check_count;
    sed_link_if link_if ();
    sed_master u_sed_master (.clk(clk), .srst(srst), .link(link_if), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_sel(cmd_sel), .cmd_alt(cmd_alt),
        .cmd_addr(cmd_addr), .cmd_len(cmd_len), .rx_data(rx_data), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .probe_ack(probe_ack), .probe_done(probe_done));
    sed_device u_sed_device (.clk(clk), .srst(srst), .link(link_if), .chip_sel(chip_sel),
        .id_locked(id_locked), .busy(dev_busy), .last_byte(last_byte));
    sed_link_assertions u_chk (.clk(clk), .srst(srst), .scl_oe_n(link_if.scl_oe_n),
        .sda_m_oe_n(link_if.sda_m_oe_n), .sda_s_oe_n(link_if.sda_s_oe_n),
        .scl(link_if.scl), .sda(link_if.sda));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        if (num_errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Idle means command port free and every noted byte already seen
    task automatic wait_idle();
        int n;
        n = 0;
        while (!(cmd_ready === 1'b1 && exp_q.size() == 0)) begin
            @(negedge clk);
            n++;
            if (n > 20000) begin
                num_errors++;
                give_verdict();
            end
        end
    endtask
    task automatic push_seq(input logic [7:0] first, input int n);
        for (int i = 0; i < n; i++) begin
            exp_q.push_back(first + 8'(i));
        end
    endtask
    task automatic run(input sed_op_e op, input logic [2:0] sel, input logic alt,
                       input logic [15:0] addr, input logic [7:0] len);
        cmd_op    <= op;
        cmd_sel   <= sel;
        cmd_alt   <= alt;
        cmd_addr  <= addr;
        cmd_len   <= len;
        cmd_valid <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        cmd_valid <= 1'b0;
        wait_idle();
    endtask
    // Random gaps in draining keep the FIFO busy; while stall is set draining stops and received bytes collect in the FIFO without filling it
    always @(negedge clk) begin
        rdy_pat  <= {rdy_pat[30:0], rdy_pat[31]};
        rx_ready <= !stall && (rdy_pat[0] || rdy_pat[1]);
    end
    always @(posedge clk) begin
        if (srst === 1'b0 && rx_valid === 1'b1 && rx_ready === 1'b1) begin
            check(rx_data, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
        end
        if (srst === 1'b0 && probe_done === 1'b1) begin
            check({7'h0, probe_ack}, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
        end
    end
    initial begin
        void'($urandom(32'hbdf0557e));
        srst = 1'b1;
        cmd_valid = 1'b0;
        cmd_op = SED_OP_CUR;
        cmd_sel = 3'h0;
        cmd_alt = 1'b0;
        cmd_addr = 16'h0000;
        cmd_len = 8'h01;
        rx_ready = 1'b0;
        stall = 1'b0;
        id_locked = 1'b0;
        num_errors = 0;
        check_count = 0;
        chip_sel = 3'($urandom);
        rdy_pat = $urandom | 32'h1;
        repeat (16) @(negedge clk);
        srst = 1'b0;
        @(negedge clk);
        push_seq(8'h10, 4);
        run(SED_OP_RAND, chip_sel, 1'b0, 16'h0010, 8'd4);
        check(last_byte, 8'h13);
        repeat (4) @(negedge clk);
        check({7'h0, dev_busy}, 8'h00);
        push_seq(8'h14, 2);
        run(SED_OP_CUR, chip_sel, 1'b0, 16'h0000, 8'd2);
        push_seq(8'hfe, 4);
        run(SED_OP_RAND, chip_sel, 1'b0, 16'h1ffe, 8'd4);
        r = $urandom;
        push_seq(8'h8a, 22);
        run(SED_OP_RAND, chip_sel, 1'b1, {r[15:12], 2'b00, r[9:5], 5'd10}, 8'd22);
        for (int i = 0; i < 34; i++) begin
            exp_q.push_back(i < 16 ? 8'hc0 + 8'(i) : (i < 32 ? 8'h00 : 8'hc0 + 8'(i - 32)));
        end
        stall = 1'b1;
        fork
            run(SED_OP_RAND, chip_sel, 1'b1, 16'h0800, 8'd34);
            begin
                repeat (600) @(negedge clk);
                check({7'h0, rx_valid}, 8'h01);
                stall = 1'b0;
            end
        join
        push_seq(8'hc3, 1);
        run(SED_OP_RAND, chip_sel, 1'b1, 16'h0803, 8'd1);
        push_seq(8'h04, 1);
        run(SED_OP_CUR, chip_sel, 1'b0, 16'h0000, 8'd1);
        for (int k = 0; k < 2; k++) begin
            id_locked = k[0];
            exp_q.push_back({7'h0, ~k[0]});
            run(SED_OP_PROBE, chip_sel, 1'b1, 16'h0000, 8'd1);
        end
        // Wrong selects must end with no byte; a stray one meets an unknown note
        for (int s = 0; s < 8; s++) begin
            if (3'(s) == chip_sel) begin
                push_seq(8'h40 + 8'(s), 1);
            end
            run(SED_OP_RAND, 3'(s), 1'b0, 16'h0040 + 16'(s), 8'd1);
        end
        give_verdict();
    end
endmodule
`default_nettype wire
